/* File: verilog/acs_defines.vh */
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// register byte offsets
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_CTRL2 12'h004
`define ACS_OFF_STATUS 12'h008
`define ACS_OFF_RESULT 12'h00C

// field positions
`define ACS_CTRL_START 0
`define ACS_STAT_DONE 0
`define ACS_STAT_SAMPLING 1
`define ACS_CTRL2_ACQ_HI 5
`define ACS_CTRL2_ACQ_LO 3
`define ACS_CTRL2_CLK_HI 2
`define ACS_CTRL2_CLK_LO 0

// reset values
`define ACS_RST_ACQ_SEL 3'h0
`define ACS_RST_CLK_SEL 3'h0
`define ACS_RST_RESULT 10'h000

// conversion clock select codes
`define ACS_CLK_DIV2 3'h0
`define ACS_CLK_DIV4 3'h4
`define ACS_CLK_DIV8 3'h1
`define ACS_CLK_DIV16 3'h5
`define ACS_CLK_DIV32 3'h2
`define ACS_CLK_DIV64 3'h6

// acquisition lengths in bit periods
`define ACS_ACQ_001 5'h02
`define ACS_ACQ_010 5'h04
`define ACS_ACQ_011 5'h06
`define ACS_ACQ_100 5'h08
`define ACS_ACQ_101 5'h0C
`define ACS_ACQ_110 5'h10
`define ACS_ACQ_111 5'h14

// timing, in system clocks of 50 ns
`define ACS_DIV2_CLKS 7'h02
`define ACS_DIV4_CLKS 7'h04
`define ACS_DIV8_CLKS 7'h08
`define ACS_DIV16_CLKS 7'h10
`define ACS_DIV32_CLKS 7'h20
`define ACS_DIV64_CLKS 7'h40
// rc bit period: 1.2 us, or 2.5 us on low-power parts
`define ACS_RC_CYCLES 7'h18
`define ACS_RC_LP_CYCLES 7'h32
`define ACS_INSTR_CYCLES 3'h4
`define ACS_CONV_TADS 4'hB
`define ACS_WAIT_TADS 4'h2
`define ACS_RES_BITS 10

// successive approximation
`define ACS_DAC_FIRST 10'h200
`define ACS_RST_DAC 10'h000
`define ACS_TOP_POS 4'hA
`define ACS_POS_ONE 11'h001

`endif

/* File: verilog/acs_tick_gen.v */
`timescale 1ns/1ns
`include "acs_defines.vh"

module acs_tick_gen (
  input wire clk, // system clock
  input wire resetn, // async reset, active low
  input wire run, // count while high, restart when low
  input wire [2:0] clkSel, // conversion clock select
  input wire lowPower, // low-power part, slower rc period
  output wire tick // one-cycle pulse per bit period
);

  reg [6:0] count;
  reg [6:0] divisor;

  always @* begin
    if (clkSel[1:0] == 2'b11) begin
      if (lowPower) begin
        divisor = `ACS_RC_LP_CYCLES;
      end else begin
        divisor = `ACS_RC_CYCLES;
      end
    end else begin
      case (clkSel)
        `ACS_CLK_DIV2: divisor = `ACS_DIV2_CLKS;
        `ACS_CLK_DIV4: divisor = `ACS_DIV4_CLKS;
        `ACS_CLK_DIV8: divisor = `ACS_DIV8_CLKS;
        `ACS_CLK_DIV16: divisor = `ACS_DIV16_CLKS;
        `ACS_CLK_DIV32: divisor = `ACS_DIV32_CLKS;
        default: divisor = `ACS_DIV64_CLKS;
      endcase
    end
  end

  assign tick = run && (count == divisor - 7'h01);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 7'h00;
    end else if (!run || tick) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'h01;
    end
  end

endmodule // acs_tick_gen

/* File: verilog/acs_sequencer.v */
`timescale 1ns/1ns
`include "acs_defines.vh"

module acs_sequencer (
  input wire clk, // system clock, 20 MHz
  input wire resetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output reg pslverr, // apb error, unmapped address
  input wire lowPower, // low-power part strap
  input wire compHigh, // comparator pin: input above dac level
  output reg [9:0] dacCode, // trial code to the capacitor dac
  output reg sampleClosed, // sampling switch closed
  output reg convDoneFlag // conversion done flag
);

  ////////////////////////////////////////////////////////////////////////
  localparam ST_SAMPLE = 3'd0;
  localparam ST_DELAY = 3'd1;
  localparam ST_ACQ = 3'd2;
  localparam ST_CONV = 3'd3;
  localparam ST_WAIT = 3'd4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg startBit;
  reg [2:0] acqSel;
  reg [2:0] clkSel;
  reg [9:0] result;
  reg [4:0] tickCnt;
  reg [2:0] delayCnt;
  reg comp1;
  reg comp2;
  reg comp3;
  reg compStable;
  reg [4:0] acqLen;
  wire tick;
  wire rcSel;
  wire apbWrite;
  wire setupRead;
  wire convEnd;
  wire abortNow;
  wire [3:0] bitPos;
  wire tickRun;
  wire convStart;
  wire trialStep;
  wire [10:0] posHot;
  wire [9:0] next_dacCode;
  reg lp1;
  reg lp2;
  reg lp3;
  reg lowPowerSync;
  localparam [9:0] DAC_FIRST = `ACS_DAC_FIRST;
  genvar b;

  ////////////////////////////////////////////////////////////////////////
  // zero wait states: answer in the access cycle
  assign pready = psel && penable;
  assign apbWrite = psel && penable && pwrite;
  assign setupRead = psel && !penable;

  assign rcSel = (clkSel[1:0] == 2'b11);

  always @* begin
    case (acqSel)
      3'h1: acqLen = `ACS_ACQ_001;
      3'h2: acqLen = `ACS_ACQ_010;
      3'h3: acqLen = `ACS_ACQ_011;
      3'h4: acqLen = `ACS_ACQ_100;
      3'h5: acqLen = `ACS_ACQ_101;
      3'h6: acqLen = `ACS_ACQ_110;
      3'h7: acqLen = `ACS_ACQ_111;
      default: acqLen = 5'd0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads prepared in the setup cycle so prdata is a flop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupRead || (psel && !penable)) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr == `ACS_OFF_CTRL) begin
        // start bit is the only busy indication
        prdata[`ACS_CTRL_START] <= startBit;
      end else if (paddr == `ACS_OFF_CTRL2) begin
        prdata[`ACS_CTRL2_ACQ_HI:`ACS_CTRL2_ACQ_LO] <= acqSel;
        prdata[`ACS_CTRL2_CLK_HI:`ACS_CTRL2_CLK_LO] <= clkSel;
      end else if (paddr == `ACS_OFF_STATUS) begin
        prdata[`ACS_STAT_DONE] <= convDoneFlag;
        prdata[`ACS_STAT_SAMPLING] <= sampleClosed;
      end else if (paddr == `ACS_OFF_RESULT) begin
        prdata[`ACS_RES_BITS-1:0] <= result;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acqSel <= `ACS_RST_ACQ_SEL;
      clkSel <= `ACS_RST_CLK_SEL;
    end else if (apbWrite && paddr == `ACS_OFF_CTRL2) begin
      acqSel <= pwdata[`ACS_CTRL2_ACQ_HI:`ACS_CTRL2_ACQ_LO];
      clkSel <= pwdata[`ACS_CTRL2_CLK_HI:`ACS_CTRL2_CLK_LO];
    end
  end

  // start bit: software write wins over the hardware clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startBit <= 1'b0;
    end else if (apbWrite && paddr == `ACS_OFF_CTRL) begin
      startBit <= pwdata[`ACS_CTRL_START];
    end else if (convEnd) begin
      startBit <= 1'b0;
    end
  end

  // done flag: write one to clear, a new completion wins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      convDoneFlag <= 1'b0;
    end else if (convEnd) begin
      convDoneFlag <= 1'b1;
    end else if (apbWrite && paddr == `ACS_OFF_STATUS &&
                 pwdata[`ACS_STAT_DONE]) begin
      convDoneFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparator pin: three flops, a change needs stages two and three
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comp1 <= 1'b0;
      comp2 <= 1'b0;
      comp3 <= 1'b0;
      compStable <= 1'b0;
    end else begin
      comp1 <= compHigh;
      comp2 <= comp1;
      comp3 <= comp2;
      if (comp2 == comp3) begin
        compStable <= comp3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap pin: same three-flop filter, so a one-clock glitch cannot
  // change the rc divisor; a lasting change applies mid bit period too
  // part type strap
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lp1 <= 1'b0;
      lp2 <= 1'b0;
      lp3 <= 1'b0;
      lowPowerSync <= 1'b0;
    end else begin
      lp1 <= lowPower;
      lp2 <= lp1;
      lp3 <= lp2;
      if (lp2 == lp3) begin
        lowPowerSync <= lp3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // restart the divider on abort so the wait gets two full periods
  assign tickRun = !abortNow &&
    (state == ST_ACQ || state == ST_CONV || state == ST_WAIT);

  // bit-period ticks from divider or rc source
  acs_tick_gen u_tick (
    .clk(clk),
    .resetn(resetn),
    .run(tickRun),
    .clkSel(clkSel),
    .lowPower(lowPowerSync),
    .tick(tick)
  );

  // clearing start aborts the delay, acquisition or conversion phase, not the wait
  assign abortNow = !startBit &&
    (state == ST_DELAY || state == ST_ACQ || state == ST_CONV);
  assign convEnd = (state == ST_CONV) && startBit && tick &&
    (tickCnt == {1'b0, `ACS_CONV_TADS} - 5'd1);
  // first tick is the hold period, then msb down to lsb
  assign bitPos = `ACS_TOP_POS - tickCnt[3:0];

  always @* begin
    next_state = state;
    case (state)
      ST_SAMPLE: begin
        if (startBit) begin
          if (rcSel) begin
            next_state = ST_DELAY;
          end else if (acqSel != 3'h0) begin
            next_state = ST_ACQ;
          end else begin
            next_state = ST_CONV;
          end
        end
      end
      ST_DELAY: begin
        if (abortNow) begin
          next_state = ST_WAIT;
        end else if (delayCnt == `ACS_INSTR_CYCLES - 3'd1) begin
          // one instruction cycle before the rc clock runs
          if (acqSel != 3'h0) begin
            next_state = ST_ACQ;
          end else begin
            next_state = ST_CONV;
          end
        end
      end
      ST_ACQ: begin
        if (abortNow) begin
          next_state = ST_WAIT;
        end else if (tick && tickCnt == acqLen - 5'd1) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abortNow || convEnd) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // two bit periods before sampling again
        if (tick && tickCnt == {1'b0, `ACS_WAIT_TADS} - 5'd1) begin
          next_state = ST_SAMPLE;
        end
      end
      default: next_state = ST_SAMPLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_SAMPLE;
      tickCnt <= 5'd0;
      delayCnt <= 3'd0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        tickCnt <= 5'd0;
        delayCnt <= 3'd0;
      end else begin
        if (tick) begin
          tickCnt <= tickCnt + 5'd1;
        end
        if (state == ST_DELAY) begin
          delayCnt <= delayCnt + 3'd1;
        end
      end
    end
  end

  // sampling resumes once back in the sample state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sampleClosed <= 1'b1;
    end else begin
      sampleClosed <= (next_state == ST_SAMPLE) ||
        (next_state == ST_ACQ) ||
        (next_state == ST_DELAY && acqSel != 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive approximation; the comparator result is sampled at the
  // end of each bit period, so the pin must settle four clocks before the period ends
  assign convStart = (state != ST_CONV) && (next_state == ST_CONV);
  assign trialStep = (state == ST_CONV) && startBit && tick &&
    (tickCnt != 5'h00);
  assign posHot = `ACS_POS_ONE << bitPos;

  // per bit: armed one step early, kept or dropped on its own step
  generate
    for (b = 0; b < `ACS_RES_BITS; b = b + 1) begin : g_trial
      assign next_dacCode[b] = convStart ? DAC_FIRST[b] :
        (trialStep && posHot[b + 1]) ? 1'b1 :
        (trialStep && posHot[b]) ? (dacCode[b] & compStable) :
        dacCode[b];
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dacCode <= `ACS_RST_DAC;
      result <= `ACS_RST_RESULT;
    end else begin
      dacCode <= next_dacCode;
      // result only written by a completed conversion
      if (convEnd) begin
        result <= {dacCode[9:1], compStable & dacCode[0]};
      end
    end
  end

endmodule // acs_sequencer

/* File: testbench/acs_seq_asserts.sv */
`timescale 1ns/1ns
`include "acs_defines.vh"
module acs_seq_asserts (
  input wire clk, // clock
  input wire resetn, // reset
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire [9:0] dacCode, // trial code
  input wire sampleClosed, // sampling switch
  input wire convDoneFlag // done flag
);
  localparam int convMin = 21;
  localparam int convMax = 720;
  reg [2:0] acqSel;
  reg [10:0] lowCnt;
  wire acc = psel && penable;
  wire w1c = acc && pwrite && paddr == `ACS_OFF_STATUS && pwdata[0];
  // shadow of the acquisition field, for the start-mode checks
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acqSel <= 3'h0;
      lowCnt <= 11'h000;
    end else begin
      if (acc && pwrite && paddr == `ACS_OFF_CTRL2)
        acqSel <= pwdata[5:3];
      if (sampleClosed)
        lowCnt <= 11'h000;
      else if (!(&lowCnt))
        lowCnt <= lowCnt + 11'h001;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence startWr;
    acc && pwrite && paddr == `ACS_OFF_CTRL && pwdata[0];
  endsequence
  sequence convEnd;
    $rose(convDoneFlag);
  endsequence
  apb_ready_a: assert property (pready == acc)
    else $error("pready differs from access phase");
  apb_err_a: assert property (acc && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `ACS_OFF_RESULT)) else $error("pslverr wrong");
  switch_open_a: assert property (
    $fell(sampleClosed) |-> ##[0:6] dacCode == 10'h200)
    else $error("conversion began without first trial code");
  manual_go_a: assert property (
    startWr ##0 (acqSel == 3'h0 && sampleClosed) |-> ##[1:6] !sampleClosed)
    else $error("manual start did not open switch");
  acq_hold_a: assert property (
    startWr ##0 (acqSel != 3'h0 && sampleClosed) |=> sampleClosed [*4])
    else $error("switch opened before acquisition ended");
  conv_len_a: assert property (
    convEnd |-> lowCnt >= convMin && lowCnt <= convMax)
    else $error("conversion length out of range");
  done_wait_a: assert property (convEnd |-> !sampleClosed [*3])
    else $error("sampling resumed without wait");
  sample_resume_a: assert property (convEnd |-> ##[1:140] sampleClosed)
    else $error("sampling did not resume");
  flag_clear_a: assert property ($fell(convDoneFlag) |-> $past(w1c))
    else $error("done flag fell without clear write");
endmodule // acs_seq_asserts

/* File: testbench/acs_analog_src.sv */
`timescale 1ns/1ns
module acs_analog_src (
  input wire clk, // clock
  input wire sampleClosed, // sampling switch closed
  input wire [9:0] dacCode, // trial code
  input wire [9:0] vin, // input, half an lsb above this code
  output wire compHigh // input above trial level
);
  reg [9:0] held;
  always @(posedge clk)
    if (sampleClosed)
      held <= vin;
  // half lsb offset keeps strict and loose compare alike
  assign compHigh = {held, 1'b1} > {dacCode, 1'b0};
endmodule // acs_analog_src

/* File: testbench/adc_acquisition_clock_sequencer_tb.sv */
`timescale 1ns/1ns
`include "acs_defines.vh"
module adc_acquisition_clock_sequencer_tb;
  reg clk, resetn, psel, penable, pwrite, lowPower, errSeen;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [9:0] vin, expRes;
  wire pready, pslverr, compHigh, sampleClosed, convDoneFlag;
  wire [31:0] prdata;
  wire [9:0] dacCode;
  integer n_mismatch = 0;
  integer checks = 0;
  integer i, n, d;
  int clkCode [8] = '{0, 4, 1, 5, 2, 6, 3, 7};
  // bit period in clocks; rc is 1.2 us or 2.5 us at 50 ns
  int tadClk [8] = '{2, 4, 8, 16, 32, 64, 24, 50};
  int acqLen [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  acs_sequencer i_dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .lowPower(lowPower),
    .compHigh(compHigh), .dacCode(dacCode), .sampleClosed(sampleClosed),
    .convDoneFlag(convDoneFlag));
  acs_analog_src i_src (.clk(clk), .sampleClosed(sampleClosed),
    .dacCode(dacCode), .vin(vin), .compHigh(compHigh));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task close_out;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] dat);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
        chk(1'b0, 1'b1);
        close_out;
      end
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // sel 0 waits for the done flag, 1 for the closed switch
  task waitSig(input sel, input integer lim);
    begin
      n = 0;
      while ((sel ? sampleClosed : convDoneFlag) !== 1'b1 && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= lim) begin
        chk(1'b0, 1'b1);
        close_out;
      end
    end
  endtask
  task clear;
    begin
      waitSig(1'b1, 200);
      apb(1'b1, `ACS_OFF_STATUS, 32'h1);
      apb(1'b0, `ACS_OFF_STATUS, 32'h0);
      chk(rd, 32'h2);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, lowPower} = 0;
    vin = 10'h155;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `ACS_OFF_CTRL2, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `ACS_OFF_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    chk(errSeen, 1'b1);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 8; i = i + 1) begin
      lowPower <= (i == 7);
      vin <= vin + 10'h05B;
      apb(1'b1, `ACS_OFF_CTRL2, clkCode[i]);
      apb(1'b0, `ACS_OFF_CTRL2, 32'h0);
      chk(rd, clkCode[i]);
      apb(1'b1, `ACS_OFF_CTRL, 32'h1);
      waitSig(1'b0, 900);
      d = tadClk[i] * 11 + ((i > 5) ? 4 : 0);
      chk(n >= d && n <= d + 5, 1'b1);
      apb(1'b0, `ACS_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `ACS_OFF_RESULT, 32'h0);
      // value only where divider suits clock
      if (i > 2)
        chk(rd, vin);
      clear;
    end
    expRes = vin;
    lowPower <= 1'b0;
    vin <= 10'h0F0;
    apb(1'b1, `ACS_OFF_CTRL2, 32'h39);
    apb(1'b1, `ACS_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    apb(1'b0, `ACS_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(sampleClosed, 1'b1);
    repeat (150) @(posedge clk);
    apb(1'b0, `ACS_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(sampleClosed, 1'b0);
    apb(1'b1, `ACS_OFF_CTRL, 32'h0);
    waitSig(1'b1, 60);
    chk(n >= 14 && n <= 22, 1'b1);
    chk(convDoneFlag, 1'b0);
    apb(1'b0, `ACS_OFF_RESULT, 32'h0);
    chk(rd, expRes);
    for (i = 1; i < 8; i = i + 1) begin
      apb(1'b1, `ACS_OFF_CTRL2, i * 8);
      apb(1'b0, `ACS_OFF_CTRL2, 32'h0);
      chk(rd, i * 8);
      apb(1'b1, `ACS_OFF_CTRL, 32'h1);
      waitSig(1'b0, 200);
      d = 22 + acqLen[i] * 2;
      chk(n >= d && n <= d + 5, 1'b1);
      clear;
    end
    close_out;
  end
endmodule // adc_acquisition_clock_sequencer_tb
bind acs_sequencer acs_seq_asserts i_chk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .dacCode(dacCode), .sampleClosed(sampleClosed),
  .convDoneFlag(convDoneFlag));
